// >>> logic/blmc_consts.svh
`ifndef BLMC_CONSTS_SVH
`define BLMC_CONSTS_SVH
// ----------------------------------------------------------------
// Setting indexes and field layout
// ----------------------------------------------------------------
`define BLMC_MR_BURST      9'h001
`define BLMC_MR_LAT        9'h002
`define BLMC_BT_BIT        3
`define BLMC_WC_BIT        4
`define BLMC_NWR_POS       5
`define BLMC_BL4           3'h2
`define BLMC_BL8           3'h3
`define BLMC_BL16          3'h4
`define BLMC_NWR_MIN       3'h1
`define BLMC_NWR_MAX       3'h6
`define BLMC_NWR_OFS       4'h2
`define BLMC_NWR_CYC_MIN   3
`define BLMC_NWR_CYC_MAX   8
`define BLMC_LAT_MIN       4'h1
`define BLMC_LAT_MAX       4'h6
`define BLMC_BURST_RST     8'h22
`define BLMC_LAT_RST       8'h01
// ----------------------------------------------------------------
// Burst and strobe figures
// ----------------------------------------------------------------
`define BLMC_NOWRAP_BAD_HI 9'h1FE
`define BLMC_NOWRAP_BAD_LO 9'h000
`define BLMC_MRD_TOGGLES   5'h04
`define BLMC_MRD_DATA      8'h00
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BLMC_CLK_NS        10
`define BLMC_LINK_DIV      16
`define BLMC_TWR_NS        15
`define BLMC_LINK_NS       (`BLMC_CLK_NS * `BLMC_LINK_DIV)
`define BLMC_TWR_CYC       ((`BLMC_TWR_NS + `BLMC_LINK_NS - 1) / `BLMC_LINK_NS)
`endif

// >>> logic/blmc_pkg.sv
`default_nettype none
`include "blmc_consts.svh"
package blmc_pkg;
	typedef enum logic [2:0] {cmd_nop, cmd_mode_wr, cmd_mode_rd, cmd_rd, cmd_wr} blmc_cmd_t;
	typedef enum logic [1:0] {dev_idle, dev_burst, dev_mode_rd} blmc_dev_st_t;
	typedef enum logic [1:0] {ctl_idle, ctl_load, ctl_hold, ctl_wait} blmc_ctl_st_t;

	// Beats per burst from the length code; reserved codes give zero
	function automatic logic [4:0] blmc_beats(input logic [2:0] code);
		case (code)
			`BLMC_BL4:  blmc_beats = 5'h04;
			`BLMC_BL8:  blmc_beats = 5'h08;
			`BLMC_BL16: blmc_beats = 5'h10;
			default:    blmc_beats = 5'h00;
		endcase
	endfunction : blmc_beats
endpackage : blmc_pkg
`default_nettype wire

// >>> logic/blmc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface blmc_if;
	import blmc_pkg::*;
	logic            link_clk;
	logic            ca_valid;
	blmc_cmd_t       ca_cmd;
	logic [8:0]      ca_addr;
	logic [7:0]      ca_data;
	logic            ca_ap;
	logic            dqs;
	logic [7:0]      dq;

	modport ctrl (
		output link_clk,
		output ca_valid,
		output ca_cmd,
		output ca_addr,
		output ca_data,
		output ca_ap,
		input  dqs,
		input  dq
	);
	modport dev (
		input  link_clk,
		input  ca_valid,
		input  ca_cmd,
		input  ca_addr,
		input  ca_data,
		input  ca_ap,
		output dqs,
		output dq
	);
endinterface : blmc_if
`default_nettype wire

// >>> logic/blmc_seq.sv
`timescale 1ns/1ps
`default_nettype none
module blmc_seq (
	input  wire logic [8:0] start_col,
	input  wire logic [3:0] beat,
	input  wire logic [2:0] bl_code,
	input  wire logic       order_type,
	input  wire logic       wrap_control,
	output logic      [8:0] col
);
	import blmc_pkg::*;
	logic [8:0] mask;
	logic [8:0] step;
	logic [8:0] low;

	// Column of one beat: start plus beat when wrap_control is set, else inside the burst-aligned block
	always_comb begin
		step = {5'h00, beat};
		mask = 9'(blmc_beats(bl_code) - 5'h01);
		if (order_type)
			low = (start_col ^ step) & mask;
		else
			low = (start_col + step) & mask;
		if (wrap_control)
			col = start_col + step;
		else
			col = (start_col & ~mask) | low;
	end
endmodule : blmc_seq
`default_nettype wire

// >>> logic/blmc_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "blmc_consts.svh"
module blmc_device (
	blmc_if.dev              link,
	input  wire logic        rst,
	output logic       [8:0] beat_col_q,
	output logic             beat_valid_q,
	output logic             beat_write_q,
	output logic             precharge_q,
	output logic       [3:0] read_latency_q,
	output logic       [2:0] write_latency_q,
	output logic       [2:0] burst_length_code_q,
	output logic             burst_order_type_q,
	output logic             wrap_control_q
);
	import blmc_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		blmc_dev_st_t st;
		logic [4:0]   beat;
		logic [4:0]   beats;
		logic [8:0]   start;
		logic         is_wr;
		logic         ap;
		logic [3:0]   pre_cnt;
		logic [7:0]   burst_cfg;
		logic [7:0]   lat_cfg;
		logic [3:0]   rl;
		logic [2:0]   wl;
		logic [8:0]   col;
		logic         col_valid;
		logic         col_wr;
		logic         precharge;
		logic         dqs;
		logic [7:0]   dq;
	} blmc_dev_state_t;

	blmc_dev_state_t s_q;
	blmc_dev_state_t s_d;
	logic      [8:0] seq_col;

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	// Length and delay codes both legal
	function automatic logic burst_ok(input logic [7:0] v);
		logic [2:0] auto_precharge_delay;
		auto_precharge_delay = v[`BLMC_NWR_POS +: 3];
		burst_ok = (blmc_beats(v[2:0]) != 5'h00) &&
			(auto_precharge_delay >= `BLMC_NWR_MIN) && (auto_precharge_delay <= `BLMC_NWR_MAX);
	endfunction : burst_ok

	// Latency code to read/write latency pair
	function automatic logic [6:0] lat_pair(input logic [3:0] code);
		case (code)
			4'h1:    lat_pair = {4'h3, 3'h1};
			4'h2:    lat_pair = {4'h4, 3'h2};
			4'h3:    lat_pair = {4'h5, 3'h2};
			4'h4:    lat_pair = {4'h6, 3'h3};
			4'h5:    lat_pair = {4'h7, 3'h4};
			4'h6:    lat_pair = {4'h8, 3'h4};
			default: lat_pair = {4'h3, 3'h1};
		endcase
	endfunction : lat_pair

	// ----------------------------------------------------------------
	// Column ordering
	// ----------------------------------------------------------------
	blmc_seq u_seq (
		.start_col    (s_q.start),
		.beat         (s_q.beat[3:0]),
		.bl_code      (s_q.burst_cfg[2:0]),
		.order_type   (s_q.burst_cfg[`BLMC_BT_BIT]),
		.wrap_control (s_q.burst_cfg[`BLMC_WC_BIT]),
		.col          (seq_col)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Commands arriving mid-burst are ignored; the controller spaces them
	always_comb begin
		s_d           = s_q;
		s_d.col_valid = 1'b0;
		s_d.precharge = 1'b0;

		// Precharge countdown runs beside any later command
		if (s_q.pre_cnt != 4'h0) begin
			s_d.pre_cnt = s_q.pre_cnt - 4'h1;
			if (s_q.pre_cnt == 4'h1)
				s_d.precharge = 1'b1;
		end

		case (s_q.st)
			dev_idle: begin
				if (link.ca_valid) begin
					case (link.ca_cmd)
						cmd_mode_wr: begin
							// Reserved codes leave the old setting in place
							if (link.ca_addr == `BLMC_MR_BURST &&
								burst_ok(link.ca_data))
								s_d.burst_cfg = link.ca_data;
							else if (link.ca_addr == `BLMC_MR_LAT &&
								link.ca_data[3:0] >= `BLMC_LAT_MIN &&
								link.ca_data[3:0] <= `BLMC_LAT_MAX)
								s_d.lat_cfg = link.ca_data;
						end
						cmd_mode_rd: begin
							s_d.st    = dev_mode_rd;
							s_d.beat  = 5'h00;
							s_d.beats = `BLMC_MRD_TOGGLES;
							s_d.dq    = `BLMC_MRD_DATA;
						end
						cmd_rd, cmd_wr: begin
							s_d.st    = dev_burst;
							s_d.beat  = 5'h00;
							s_d.start = {link.ca_addr[8:1], 1'b0};
							s_d.is_wr = (link.ca_cmd == cmd_wr);
							s_d.ap    = link.ca_ap;
							if (s_q.burst_cfg[`BLMC_WC_BIT])
								s_d.beats = blmc_beats(`BLMC_BL4);
							else
								s_d.beats = blmc_beats(s_q.burst_cfg[2:0]);
						end
						default: begin
						end
					endcase
				end
			end
			dev_burst: begin
				// One column per link cycle
				s_d.col       = seq_col;
				s_d.col_valid = 1'b1;
				s_d.col_wr    = s_q.is_wr;
				s_d.beat      = s_q.beat + 5'h01;
				if (s_q.beat == s_q.beats - 5'h01) begin
					s_d.st = dev_idle;
					if (s_q.is_wr && s_q.ap)
						s_d.pre_cnt = {1'b0, s_q.burst_cfg[`BLMC_NWR_POS +: 3]}
							+ `BLMC_NWR_OFS;
				end
			end
			dev_mode_rd: begin
				// Strobe toggles although the data means nothing
				s_d.dqs  = ~s_q.dqs;
				s_d.beat = s_q.beat + 5'h01;
				if (s_q.beat == s_q.beats - 5'h01)
					s_d.st = dev_idle;
			end
			default: s_d.st = dev_idle;
		endcase

		// Latency pair kept registered so outputs come from flops
		{s_d.rl, s_d.wl} = lat_pair(s_d.lat_cfg[3:0]);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Settings reset to their defaults: four beats, sequential, wrap
	always_ff @(posedge link.link_clk or posedge rst) begin
		if (rst) begin
			s_q           <= '0;
			s_q.st        <= dev_idle;
			s_q.burst_cfg <= `BLMC_BURST_RST;
			s_q.lat_cfg   <= `BLMC_LAT_RST;
			s_q.rl        <= 4'h3;
			s_q.wl        <= 3'h1;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign link.dqs            = s_q.dqs;
	assign link.dq             = s_q.dq;
	assign beat_col_q          = s_q.col;
	assign beat_valid_q        = s_q.col_valid;
	assign beat_write_q        = s_q.col_wr;
	assign precharge_q         = s_q.precharge;
	assign read_latency_q      = s_q.rl;
	assign write_latency_q     = s_q.wl;
	assign burst_length_code_q = s_q.burst_cfg[2:0];
	assign burst_order_type_q  = s_q.burst_cfg[`BLMC_BT_BIT];
	assign wrap_control_q      = s_q.burst_cfg[`BLMC_WC_BIT];
endmodule : blmc_device
`default_nettype wire

// >>> logic/blmc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "blmc_consts.svh"
module blmc_ctrl (
	input  wire logic                clk,
	input  wire logic                rst,
	blmc_if.ctrl                     link,
	input  wire logic                req_valid,
	input  wire blmc_pkg::blmc_cmd_t req_cmd,
	input  wire logic          [8:0] req_addr,
	input  wire logic          [7:0] req_data,
	input  wire logic                req_ap,
	output logic                     req_ready_q,
	output logic                     req_refused_q,
	output logic                     strobe_edge_q
);
	import blmc_pkg::*;

	// ----------------------------------------------------------------
	// Constants and state
	// ----------------------------------------------------------------
	localparam int TWR_CYC = `BLMC_TWR_CYC;
	localparam int NWR_CYC = (TWR_CYC < `BLMC_NWR_CYC_MIN) ? `BLMC_NWR_CYC_MIN :
		(TWR_CYC > `BLMC_NWR_CYC_MAX) ? `BLMC_NWR_CYC_MAX : TWR_CYC;
	localparam logic [2:0] NWR_CODE = 3'(NWR_CYC - 2);

	typedef struct packed {
		logic [3:0]   div;
		logic         link_clk;
		blmc_ctl_st_t st;
		logic         ca_valid;
		blmc_cmd_t    ca_cmd;
		logic [8:0]   ca_addr;
		logic [7:0]   ca_data;
		logic         ca_ap;
		logic [4:0]   wait_cnt;
		logic [2:0]   bl;
		logic         wc;
		logic         ready;
		logic         refused;
		logic [2:0]   dqs_s;
		logic         edge_seen;
	} blmc_ctl_state_t;

	blmc_ctl_state_t s_q;
	blmc_ctl_state_t s_d;
	logic            legal;

	// ----------------------------------------------------------------
	// Legality
	// ----------------------------------------------------------------
	// Setting write that the device may legally receive
	function automatic logic mode_ok(input logic [8:0] a, input logic [7:0] v);
		if (a == `BLMC_MR_BURST)
			mode_ok = (blmc_beats(v[2:0]) != 5'h00) &&
				(!v[`BLMC_WC_BIT] || v[2:0] == `BLMC_BL4) &&
				(!v[`BLMC_BT_BIT] || v[2:0] != `BLMC_BL16);
		else if (a == `BLMC_MR_LAT)
			mode_ok = v[3:0] >= `BLMC_LAT_MIN && v[3:0] <= `BLMC_LAT_MAX;
		else
			mode_ok = 1'b0;
	endfunction : mode_ok

	// No-wrap starts near the page ends are forbidden
	function automatic logic col_ok(input logic [8:0] c, input logic wc);
		col_ok = !wc || ({c[8:1], 1'b0} != `BLMC_NOWRAP_BAD_HI &&
			{c[8:1], 1'b0} != `BLMC_NOWRAP_BAD_LO);
	endfunction : col_ok

	always_comb begin
		case (req_cmd)
			cmd_mode_wr:    legal = mode_ok(req_addr, req_data);
			cmd_rd, cmd_wr: legal = col_ok(req_addr, s_q.wc);
			cmd_mode_rd:    legal = 1'b1;
			default:        legal = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// ca_valid changes at the link falling edge, div wrapping to 0; the command fields load when a request is taken
	always_comb begin
		s_d           = s_q;
		s_d.div       = s_q.div + 4'h1;
		s_d.link_clk  = s_d.div[3];
		s_d.refused   = 1'b0;
		s_d.dqs_s     = {s_q.dqs_s[1:0], link.dqs};
		s_d.edge_seen = s_q.dqs_s[2] ^ s_q.dqs_s[1];

		case (s_q.st)
			ctl_idle: begin
				if (req_valid && legal) begin
					s_d.st      = ctl_load;
					s_d.ready   = 1'b0;
					s_d.ca_cmd  = req_cmd;
					s_d.ca_ap   = req_ap;
					s_d.ca_addr = req_addr;
					s_d.ca_data = req_data;
					if (req_cmd == cmd_rd || req_cmd == cmd_wr)
						s_d.ca_addr = {req_addr[8:1], 1'b0};
					if (req_cmd == cmd_mode_wr && req_addr == `BLMC_MR_BURST) begin
						s_d.ca_data[`BLMC_NWR_POS +: 3] = NWR_CODE;
						s_d.bl = req_data[2:0];
						s_d.wc = req_data[`BLMC_WC_BIT];
					end
					if (req_cmd == cmd_mode_wr && req_addr == `BLMC_MR_LAT)
						s_d.ca_data[7:4] = 4'h0;
					case (req_cmd)
						cmd_rd, cmd_wr:
							s_d.wait_cnt = req_cmd == cmd_rd || !s_q.wc ?
								blmc_beats(s_q.wc ? `BLMC_BL4 : s_q.bl) :
								blmc_beats(`BLMC_BL4);
						cmd_mode_rd: s_d.wait_cnt = `BLMC_MRD_TOGGLES;
						default:     s_d.wait_cnt = 5'h00;
					endcase
				end else if (req_valid) begin
					s_d.refused = 1'b1;
				end
			end
			ctl_load: if (s_q.div == 4'hF) begin
				s_d.ca_valid = 1'b1;
				s_d.st       = ctl_hold;
			end
			ctl_hold: if (s_q.div == 4'hF) begin
				s_d.ca_valid = 1'b0;
				s_d.st       = ctl_wait;
			end
			ctl_wait: if (s_q.div == 4'hF) begin
				if (s_q.wait_cnt == 5'h00) begin
					s_d.st    = ctl_idle;
					s_d.ready = 1'b1;
				end else begin
					s_d.wait_cnt = s_q.wait_cnt - 5'h01;
				end
			end
			default: s_d.st = ctl_idle;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q       <= '0;
			s_q.st    <= ctl_idle;
			s_q.bl    <= `BLMC_BL4;
			s_q.ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.link_clk = s_q.link_clk;
	assign link.ca_valid = s_q.ca_valid;
	assign link.ca_cmd   = s_q.ca_cmd;
	assign link.ca_addr  = s_q.ca_addr;
	assign link.ca_data  = s_q.ca_data;
	assign link.ca_ap    = s_q.ca_ap;
	assign req_ready_q   = s_q.ready;
	assign req_refused_q = s_q.refused;
	assign strobe_edge_q = s_q.edge_seen;
endmodule : blmc_ctrl
`default_nettype wire

// >>> testbench/blmc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Checks on the link between controller and device
// ----------------------------------------------------------------
module blmc_asserts (
	input wire logic                link_clk,
	input wire logic                rst,
	input wire logic                ca_valid,
	input wire blmc_pkg::blmc_cmd_t ca_cmd,
	input wire logic          [8:0] ca_addr,
	input wire logic          [7:0] ca_data,
	input wire logic                ca_ap,
	input wire logic                dqs,
	input wire logic          [7:0] dq
);
	import blmc_pkg::*;
	logic bw, lw, rw, nowrap_q, nowrap_d;
	default clocking cb @(posedge link_clk);
	endclocking
	default disable iff (rst);
	// Command decodes; ca_valid spans exactly one link edge
	assign bw = ca_valid && ca_cmd == cmd_mode_wr && ca_addr == 9'h001;
	assign lw = ca_valid && ca_cmd == cmd_mode_wr && ca_addr == 9'h002;
	assign rw = ca_valid && (ca_cmd == cmd_rd || ca_cmd == cmd_wr);
	// Wrap shadow; illegal writes are refused upstream, so each sent write lands
	always_comb nowrap_d = bw ? ca_data[4] : nowrap_q;
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) nowrap_q <= 1'b0;
		else nowrap_q <= nowrap_d;
	end
	length_code_legal_a: assert property (bw |-> ca_data[2:0] inside {3'h2, 3'h3, 3'h4})
		else $error("reserved burst length sent");
	nowrap_four_only_a: assert property (bw && ca_data[4] |-> ca_data[2:0] == 3'h2)
		else $error("no-wrap sent with long burst");
	delay_code_legal_a: assert property (bw |-> ca_data[7:5] inside {[3'h1:3'h6]})
		else $error("reserved precharge delay code sent");
	delay_code_value_a: assert property (bw |-> ca_data[7:5] == 3'h1)
		else $error("precharge delay not rounded-up recovery");
	start_col_even_a: assert property (rw |-> ca_addr[0] == 1'b0)
		else $error("odd start column on the link");
	interleave_not_sixteen_a: assert property (bw && ca_data[3] |-> ca_data[2:0] != 3'h4)
		else $error("interleave sent with sixteen beats");
	nowrap_start_legal_a: assert property (rw && nowrap_q |->
		!(ca_addr inside {9'h1FE, 9'h1FF, 9'h000, 9'h001})) else $error("no-wrap start at page edge");
	latency_code_legal_a: assert property (lw |-> ca_data[3:0] inside {[4'h1:4'h6]})
		else $error("reserved latency code sent");
	latency_upper_zero_a: assert property (lw |-> ca_data[7:4] == 4'h0)
		else $error("unused latency bits not zero");
	strobe_toggles_a: assert property (ca_valid && ca_cmd == cmd_mode_rd |->
		##2 $changed(dqs) [*4]) else $error("strobe did not toggle four times");
endmodule : blmc_asserts
`default_nettype wire

// >>> testbench/burst_and_latency_mode_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
module burst_and_latency_mode_config_bench;
	import blmc_pkg::*;
	logic       clk, rst, req_valid, req_ap, ready, refused, strobe, bvalid, bwrite, pre, bot, wc;
	blmc_cmd_t  req_cmd;
	logic [8:0] req_addr, bcol;
	logic [7:0] req_data;
	logic [3:0] rl;
	logic [2:0] wl, blc;
	int         num_errors, check_count, lcnt, tlast, npre, auto_precharge_delay, scnt;
	logic [8:0] beats[$];
	blmc_if link ();
	blmc_ctrl blmc_ctrl_i (.clk(clk), .rst(rst), .link(link.ctrl), .req_valid(req_valid),
		.req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data), .req_ap(req_ap),
		.req_ready_q(ready), .req_refused_q(refused), .strobe_edge_q(strobe));
	blmc_device blmc_device_i (.link(link.dev), .rst(rst), .beat_col_q(bcol), .beat_valid_q(bvalid),
		.beat_write_q(bwrite), .precharge_q(pre), .read_latency_q(rl), .write_latency_q(wl),
		.burst_length_code_q(blc), .burst_order_type_q(bot), .wrap_control_q(wc));
	blmc_asserts blmc_asserts_i (.link_clk(link.link_clk), .rst(rst), .ca_valid(link.ca_valid),
		.ca_cmd(link.ca_cmd), .ca_addr(link.ca_addr), .ca_data(link.ca_data), .ca_ap(link.ca_ap),
		.dqs(link.dqs), .dq(link.dq));
	// ----------------------------------------------------------------
	// Clock, monitors and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Link outputs sampled mid-cycle, clear of the edge that moves them
	always @(negedge link.link_clk) begin
		lcnt++;
		if (bvalid === 1'b1) begin
			beats.push_back(bcol);
			tlast = lcnt;
			auto_precharge_delay += (bwrite === 1'b1);
		end
		if (pre === 1'b1) npre = lcnt - tlast;
	end
	always @(negedge clk) if (strobe === 1'b1) scnt++;
	// A hang counts as a failure; the full run needs about 2,000 clocks, this is 20,000
	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : check
	// One request; the refusal pulse lasts one clock, so it is read at the first negedge
	task automatic req(input blmc_cmd_t c, input logic [8:0] a, input logic [7:0] d,
		input logic ap, output logic r);
		r = 1'b0;
		@(negedge clk);
		req_valid = 1'b1;
		req_cmd = c;
		req_addr = a;
		req_data = d;
		req_ap = ap;
		@(negedge clk);
		r = (refused === 1'b1);
		req_valid = 1'b0;
		// A request that never finishes is left to the watchdog
		while (ready !== 1'b1) @(negedge clk);
	endtask : req
	task automatic wr(input logic [8:0] idx, input logic [7:0] d, input logic expref);
		logic r;
		req(cmd_mode_wr, idx, d, 1'b0, r);
		check(r === expref, "setting write accept or refuse wrong");
	endtask : wr
	function automatic logic [8:0] exp_col(input logic [8:0] s, input int i, input int bl,
		input logic il, input logic nw);
		logic [8:0] m;
		m = 9'(bl - 1);
		s[0] = 1'b0;
		if (nw) exp_col = s + 9'(i);
		else if (il) exp_col = (s & ~m) | ((s ^ 9'(i)) & m);
		else exp_col = (s & ~m) | ((s + 9'(i)) & m);
	endfunction : exp_col
	task automatic burst(input blmc_cmd_t c, input logic [8:0] s, input int bl, input logic il,
		input logic nw);
		logic r;
		beats.delete();
		req(c, s, 8'h00, 1'b0, r);
		check(r === 1'b0 && beats.size() == bl, "burst refused or beat count wrong");
		foreach (beats[i]) check(beats[i] === exp_col(s, i, bl, il, nw), "column order");
	endtask : burst
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_sequential;
		wr(9'h001, 8'h25, 1'b1);
		burst(cmd_rd, 9'h00B, 4, 1'b0, 1'b0);
		wr(9'h001, 8'h23, 1'b0);
		burst(cmd_wr, 9'h00A, 8, 1'b0, 1'b0);
		wr(9'h001, 8'h24, 1'b0);
		burst(cmd_rd, 9'h01A, 16, 1'b0, 1'b0);
		check(blc === 3'h4, "length code not held");
	endtask : t_sequential
	task automatic t_interleave;
		wr(9'h001, 8'h2A, 1'b0);
		burst(cmd_rd, 9'h006, 4, 1'b1, 1'b0);
		wr(9'h001, 8'h2B, 1'b0);
		burst(cmd_rd, 9'h016, 8, 1'b1, 1'b0);
		wr(9'h001, 8'h2C, 1'b1);
		check(bot === 1'b1 && blc === 3'h3, "order or length lost");
	endtask : t_interleave
	task automatic t_nowrap;
		logic r;
		wr(9'h001, 8'h33, 1'b1);
		wr(9'h001, 8'h32, 1'b0);
		check(wc === 1'b1, "wrap bit not set");
		burst(cmd_rd, 9'h1FC, 4, 1'b0, 1'b1);
		req(cmd_rd, 9'h1FE, 8'h00, 1'b0, r);
		check(r === 1'b1, "no-wrap start at 1FE taken");
		req(cmd_wr, 9'h000, 8'h00, 1'b0, r);
		check(r === 1'b1, "no-wrap start at 000 taken");
		wr(9'h001, 8'h22, 1'b0);
	endtask : t_nowrap
	task automatic t_latency;
		logic [3:0] rlx[6] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
		logic [2:0] wlx[6] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4};
		// Upper bits set on purpose: the controller must clear them
		for (int i = 0; i < 6; i++) begin
			wr(9'h002, 8'hA1 + 8'(i), 1'b0);
			check(rl === rlx[i] && wl === wlx[i], "latency decode");
		end
		wr(9'h002, 8'h07, 1'b1);
		wr(9'h003, 8'h01, 1'b1);
		check(rl === 4'h8, "reserved latency changed setting");
	endtask : t_latency
	task automatic t_precharge;
		logic r;
		npre = -1;
		auto_precharge_delay = 0;
		req(cmd_wr, 9'h010, 8'h00, 1'b1, r);
		for (int n = 0; n < 2000 && npre < 0; n++) @(negedge clk);
		// Recovery rounds up to one link cycle, clamped to code 001, i.e. 3 cycles
		check(r === 1'b0 && npre == 3, "precharge delay");
		check(auto_precharge_delay == 4, "write beats not flagged");
	endtask : t_precharge
	task automatic t_setting_read;
		logic r;
		scnt = 0;
		req(cmd_mode_rd, 9'h001, 8'h00, 1'b0, r);
		// Strobe edges pass a synchroniser, so let them drain
		repeat (64) @(negedge clk);
		check(r === 1'b0 && scnt == 4, "strobe edge count");
	endtask : t_setting_read
	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req_cmd = cmd_nop;
		req_addr = 9'h000;
		req_data = 8'h00;
		req_ap = 1'b0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		check(blc === 3'h2 && bot === 1'b0 && wc === 1'b0, "burst defaults");
		check(rl === 4'h3 && wl === 3'h1, "latency defaults");
		t_sequential();
		t_interleave();
		t_nowrap();
		t_latency();
		t_precharge();
		t_setting_read();
		end_of_test();
	end
endmodule : burst_and_latency_mode_config_bench
`default_nettype wire
